// >>> src/fault_irq_map.svh
// Register map, field positions and reset values of the fault status block.
// Assumes the includer uses the names below as plain constants.
`ifndef FAULT_IRQ_MAP_SVH
`define FAULT_IRQ_MAP_SVH
// Register word indices; the APB byte address is four times the index.
`define IDX_PWR_ENABLE   12'h050
`define IDX_LED_ENABLE   12'h052
`define IDX_PWR_STATUS   12'h054
`define IDX_LED_FLAGS    12'h056
// Status flag positions in the power and thermal status word.
`define POS_OVH          15
`define POS_TEMP_HI      13
`define POS_TEMP_LO      11
`define POS_OVL          7
`define POS_OCP          5
`define POS_UVLO         3
`define POS_TSD          1
// Enable field upper bit positions in the power and thermal enable word.
`define EPOS_GLOBAL      15
`define EPOS_OVH         13
`define EPOS_TEMP        11
`define EPOS_OVL         7
`define EPOS_OCP         5
`define EPOS_UVLO        3
`define EPOS_TSD         1
// Positions in the String_fault_summary_flag and enable words.
`define POS_CHAN_LSB     10
`define POS_OPEN         9
`define POS_SHORT        8
`define POS_SUMMARY      7
`define EPOS_LED         7
// Enable field codes: written 1h disables, 3h enables; reads 0h or 2h.
`define EN_WR_OFF        2'h1
`define EN_WR_ON         2'h3
`define EN_RD_ON         2'h2
// Reset values (power enable word resets to A02Ah, LED enable word to 80h).
`define RST_GLOBAL_EN    1'b1
`define RST_PWR_EN       6'h27
`define RST_LED_EN       1'b1
`endif

// >>> src/fault_irq_pkg.sv
// Types shared by the fault status block.
// Assumes nothing of its surroundings.
package fault_irq_pkg;
  // Whole state of the block, registered as one word.
  typedef struct packed {
    logic [6:0]  pwrFlag;      // ovh, temp hi, temp lo, ovl, ocp, uvlo, tsd.
    logic [5:0]  chanFlag;     // Channel 5 down to channel 0.
    logic        openFlag;     // Open string indication.
    logic        shortFlag;    // Shorted string indication.
    logic        summaryFlag;  // Summary LED fault flag.
    logic        globalEn;     // Global interrupt enable.
    logic [5:0]  pwrEn;        // ovh, temp, ovl, ocp, uvlo, tsd enables.
    logic        ledEn;        // LED fault interrupt enable.
    logic [31:0] rdData;       // Read data captured in the setup cycle.
    logic        rdErr;        // Error answer captured in the setup cycle.
  } state_s;
endpackage

// >>> src/fault_interrupt_status.sv
// Fault interrupt status flags, interrupt enables and the fault pin.
// Assumes fault detectors give one-cycle set pulses on sys_clk and that
// software reaches the registers through an APB master on the same clock.
//
// Notes on behaviour
// - Flag reads zero idle, one once latched.
// - Clear needs flag and clear bit written together.
// - Over-voltage high at 15/14, temp high 13/12.
// - Temp low at 11/10; bits 9-8 read zero.
// - Over-voltage low 7/6, over-current 5/4.
// - Undervoltage lockout 3/2, thermal shutdown 1/0.
// - Channel flags 15-10, cleared with summary flag.
// - Open bit 9, short bit 8, cleared likewise.
// - Summary flag 7/6 clears all LED flags, pin.
// - LED bits 5-0 read zero; fields reset zero.
// - Two-bit enables; global enable gates the pin.
//
// The APB register port is this design's own decision.
`include "fault_irq_map.svh"

module fault_interrupt_status
  import fault_irq_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [6:0]  pwrFaultSet,
  input  wire logic [5:0]  chanFaultSet,
  input  wire logic        openFaultSet,
  input  wire logic        shortFaultSet,
  output logic             faultIrq
);

  // Byte addresses derived from the printed register indices.
  localparam logic [11:0] ADDR_PWR_EN = 12'(`IDX_PWR_ENABLE * 4);
  localparam logic [11:0] ADDR_LED_EN = 12'(`IDX_LED_ENABLE * 4);
  localparam logic [11:0] ADDR_PWR_ST = 12'(`IDX_PWR_STATUS * 4);
  localparam logic [11:0] ADDR_LED_ST = 12'(`IDX_LED_FLAGS * 4);

  // Status bit position of each power flag, index 6 down to 0.
  localparam int STPOS [7] = '{`POS_TSD, `POS_UVLO, `POS_OCP, `POS_OVL,
                               `POS_TEMP_LO, `POS_TEMP_HI, `POS_OVH};
  // Enable field position of each power enable, index 5 down to 0.
  localparam int ENPOS [6] = '{`EPOS_TSD, `EPOS_UVLO, `EPOS_OCP,
                               `EPOS_OVL, `EPOS_TEMP, `EPOS_OVH};

  state_s st;       // Registered state.
  state_s next_st;  // Next state.

  logic setupCyc;   // APB setup cycle.
  logic wrAccess;   // Write completing at this edge.
  logic wrPwrSt;    // Write to the power status word.
  logic wrLedSt;    // Write to the String_fault_summary_flag word.
  logic wrPwrEn;    // Write to the power enable word.
  logic wrLedEn;    // Write to the LED enable word.
  logic lowLanes;   // Both low byte lanes strobed.
  logic [6:0] pwrClr;  // Valid clear requests for power flags.
  logic ledClr;        // Valid clear request for the LED flags.
  logic [6:0] pwrIrq;  // Power flags gated by their enables.

  // Next enable bit from a written two-bit field; 0h and 2h keep it.
  function automatic logic enUpdate(input logic cur, input logic [1:0] f);
    logic r;
    r = cur;
    if (f == `EN_WR_OFF)
    begin
      r = 1'b0;
    end
    else if (f == `EN_WR_ON)
    begin
      r = 1'b1;
    end
    return r;
  endfunction

  // Two-bit readback of an enable bit: 2h when on, else 0h.
  function automatic logic [1:0] enRead(input logic en);
    return en ? `EN_RD_ON : 2'h0;
  endfunction

  // True when a status bit and its paired clear bit are both written one.
  function automatic logic pairHit(input logic [15:0] d, input int pos);
    return d[pos] & d[pos-1];
  endfunction

  // Bus decode; pready is always high so every access ends in one cycle.
  always_comb
  begin
    setupCyc = psel & ~penable;
    wrAccess = psel & penable & pwrite;
    lowLanes = &pstrb[1:0];
    wrPwrSt  = wrAccess & lowLanes & (paddr == ADDR_PWR_ST);
    wrLedSt  = wrAccess & lowLanes & (paddr == ADDR_LED_ST);
    wrPwrEn  = wrAccess & lowLanes & (paddr == ADDR_PWR_EN);
    wrLedEn  = wrAccess & lowLanes & (paddr == ADDR_LED_EN);
  end

  // Clear requests: only a write with both bits of a pair set counts.
  always_comb
  begin
    for (int i = 0; i < 7; i++)
    begin
      pwrClr[i] = wrPwrSt & pairHit(pwdata[15:0], STPOS[i]);
    end
    ledClr = wrLedSt & pairHit(pwdata[15:0], `POS_SUMMARY);
  end

  // Interrupt gating; both temperature flags share one enable.
  always_comb
  begin
    pwrIrq[6] = st.pwrFlag[6] & st.pwrEn[5];
    pwrIrq[5] = st.pwrFlag[5] & st.pwrEn[4];
    pwrIrq[4] = st.pwrFlag[4] & st.pwrEn[4];
    for (int i = 0; i < 4; i++)
    begin
      pwrIrq[i] = st.pwrFlag[i] & st.pwrEn[i];
    end
  end

  // Next state: flag latching, clears, enable writes and read capture.
  always_comb
  begin
    next_st = st;
    // A new fault in the cycle of its clear wins over the clear.
    for (int i = 0; i < 7; i++)
    begin
      if (pwrFaultSet[i])
      begin
        next_st.pwrFlag[i] = 1'b1;
      end
      else if (pwrClr[i])
      begin
        next_st.pwrFlag[i] = 1'b0;
      end
    end
    // The LED group clears as a whole through the summary pair.
    if (ledClr)
    begin
      next_st.chanFlag    = 6'h00;
      next_st.openFlag    = 1'b0;
      next_st.shortFlag   = 1'b0;
      next_st.summaryFlag = 1'b0;
    end
    next_st.chanFlag  = next_st.chanFlag | chanFaultSet;
    if (openFaultSet)
    begin
      next_st.openFlag = 1'b1;
    end
    if (shortFaultSet)
    begin
      next_st.shortFlag = 1'b1;
    end
    // Any LED fault raises the summary flag.
    if (|chanFaultSet | openFaultSet | shortFaultSet)
    begin
      next_st.summaryFlag = 1'b1;
    end
    // Enable words: each two-bit field updates only on 1h or 3h.
    if (wrPwrEn)
    begin
      next_st.globalEn = enUpdate(st.globalEn,
                                  pwdata[`EPOS_GLOBAL -: 2]);
      for (int i = 0; i < 6; i++)
      begin
        next_st.pwrEn[i] = enUpdate(st.pwrEn[i],
                                    pwdata[ENPOS[i] -: 2]);
      end
    end
    if (wrLedEn)
    begin
      next_st.ledEn = enUpdate(st.ledEn, pwdata[`EPOS_LED -: 2]);
    end
    // Read data and error are captured in the setup cycle.
    if (setupCyc)
    begin
      next_st.rdData = 32'h0000_0000;
      next_st.rdErr  = 1'b0;
      unique case (paddr)
        ADDR_PWR_ST:
        begin
          // Clear bits and bits 9-8 always read zero.
          for (int i = 0; i < 7; i++)
          begin
            next_st.rdData[STPOS[i]] = st.pwrFlag[i];
          end
        end
        ADDR_LED_ST:
        begin
          // Bit 6 and bits 5-0 read zero.
          next_st.rdData[15:10]        = st.chanFlag;
          next_st.rdData[`POS_OPEN]    = st.openFlag;
          next_st.rdData[`POS_SHORT]   = st.shortFlag;
          next_st.rdData[`POS_SUMMARY] = st.summaryFlag;
        end
        ADDR_PWR_EN:
        begin
          next_st.rdData[`EPOS_GLOBAL -: 2] = enRead(st.globalEn);
          for (int i = 0; i < 6; i++)
          begin
            next_st.rdData[ENPOS[i] -: 2] = enRead(st.pwrEn[i]);
          end
        end
        ADDR_LED_EN:
        begin
          next_st.rdData[`EPOS_LED -: 2] = enRead(st.ledEn);
        end
        default:
        begin
          // Unmapped address answers with an error and zero data.
          next_st.rdErr = 1'b1;
        end
      endcase
    end
  end

  // State register; synchronous reset clears every flag.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st             <= '0;
      st.globalEn    <= `RST_GLOBAL_EN;
      st.pwrEn       <= `RST_PWR_EN;
      st.ledEn       <= `RST_LED_EN;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs: data and error from flops, pin from enabled flags.
  always_comb
  begin
    prdata   = st.rdData;
    pslverr  = st.rdErr & psel & penable;
    pready   = 1'b1;
    faultIrq = st.globalEn &
               ((|pwrIrq) | (st.summaryFlag & st.ledEn));
  end

  // Assertions share the clock and the reset.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  logic rdPwr;  // Setup cycle of a power status read.
  logic rdLed;  // Setup cycle of an String_fault_summary_flag read.
  assign rdPwr = setupCyc & (paddr == ADDR_PWR_ST);
  assign rdLed = setupCyc & (paddr == ADDR_LED_ST);

  AST_FLAG_STAYS: assert property (
    st.pwrFlag[6] && !pwrClr[6] |=> st.pwrFlag[6]
  ) else $error("Latched fault flag dropped without a clear.");

  // A set pulse shows as a latched flag one cycle later.
  AST_TSD_LATCH: assert property (
    pwrFaultSet[0] |=> st.pwrFlag[0]
  ) else $error("Thermal shutdown fault not latched.");

  AST_PAIR_CLEARS: assert property (
    wrPwrSt && pwdata[15] && pwdata[14] && !pwrFaultSet[6]
      |=> !st.pwrFlag[6]
  ) else $error("Paired write did not clear the flag.");

  // Readback places each flag at its status bit, with its clear bit zero.
  AST_OVH_READ: assert property (
    rdPwr && st.pwrFlag[6] |=> prdata[15] && !prdata[14]
  ) else $error("Over-voltage high flag not at bit 15.");

  AST_TEMP_HIGH_READ: assert property (
    rdPwr && st.pwrFlag[5] && !penable |=> prdata[13] && !prdata[12]
  ) else $error("Temperature high flag not at bit 13.");

  AST_RSVD_PWR: assert property (
    rdPwr |=> prdata[9:8] == 2'h0 && prdata[10] == 1'b0
  ) else $error("Reserved or clear bits read nonzero.");

  AST_OVL_LATCH: assert property (
    pwrFaultSet[3] |=> st.pwrFlag[3]
  ) else $error("Over-voltage low fault not latched.");

  AST_OVL_READ: assert property (
    rdPwr && st.pwrFlag[3] |=> prdata[7] && !prdata[6]
  ) else $error("Over-voltage low flag not at bit 7.");

  AST_UVLO_READ: assert property (
    rdPwr && st.pwrFlag[1] |=> prdata[3] && !prdata[2]
  ) else $error("Lockout flag not at bit 3.");

  AST_CHAN_CLEAR: assert property (
    ledClr && chanFaultSet == 6'h00 |=> st.chanFlag == 6'h00
  ) else $error("Channel flags survived a summary clear.");

  AST_OPEN_SUMMARY: assert property (
    openFaultSet |=> st.openFlag && st.summaryFlag
  ) else $error("Open string fault did not raise both flags.");

  // A summary clear with no other pending cause must release the pin.
  AST_SUMMARY_PIN: assert property (
    ledClr && pwrFaultSet == 7'h00 && chanFaultSet == 6'h00 && !openFaultSet
      && !shortFaultSet && pwrIrq == 7'h00 |=> !st.summaryFlag && !faultIrq
  ) else $error("Summary clear did not release the pin.");

  AST_RSVD_LED: assert property (
    rdLed |=> prdata[6:0] == {1'b0, 6'h00} ##1 1'b1
  ) else $error("LED reserved bits read nonzero.");

  AST_GLOBAL_OFF: assert property (
    wrPwrEn && pwdata[15:14] == `EN_WR_OFF |=> !st.globalEn && !faultIrq
  ) else $error("Global disable did not silence the pin.");

  // Half a pair, status or clear alone, must leave a latched flag set.
  AST_LONE_STATUS: assert property (
    wrPwrSt && pwdata[1] && !pwdata[0] && st.pwrFlag[0]
      |=> st.pwrFlag[0] [*2]
  ) else $error("Status-only write changed the flag.");

  AST_LONE_CLEAR: assert property (
    wrPwrSt && !pwdata[1] && pwdata[0] && st.pwrFlag[0] |=> st.pwrFlag[0]
  ) else $error("Clear-only write changed the flag.");

  AST_LED_LONE: assert property (
    wrLedSt && (pwdata[7] != pwdata[6]) && st.summaryFlag |=> st.summaryFlag
  ) else $error("Half-pair write changed the summary flag.");

  COV_PWR_CLEAR: cover property (
    st.pwrFlag[0] ##1 pwrClr[0] ##1 !st.pwrFlag[0]
  );

  COV_STRING_FAULT_SUMMARY_CLR: cover property (
    st.summaryFlag && st.chanFlag != 6'h00 ##1 ledClr
  );

  COV_SET_BEATS_CLEAR: cover property (
    pwrClr[2] && pwrFaultSet[2]
  );

  // A status-only write lands on a latched thermal shutdown flag.
  COV_LONE_WRITE: cover property (
    wrPwrSt && pwdata[1] && !pwdata[0] && st.pwrFlag[0]
  );

endmodule  // fault_interrupt_status

// >>> dv/host_model.sv
// Host model: an APB master that reads fault flags and clears them in pairs.
// Assumes the slave shares sys_clk and ends each access with pready.
module host_model (
  input  wire logic        sys_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hung;     // Set when an access never saw pready.
  logic lastErr;  // Error answer of the last access.

  // Bus idles low before the first transfer.
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, hung, lastErr} = '0;
  end

  // One transfer: setup cycle, then access held until pready is sampled high.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d,
                      output logic [31:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge sys_clk);
      n++;
    end
    hung |= (n == 16);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show a changed value, never the last one.
    paddr <= ~a;
    pwdata <= ~{16'h0000, d};
  endtask

  // A clear always writes the flag and its paired clear bit together.
  task automatic clear_pair(input logic [11:0] a, input logic [15:0] flagMask);
    logic [31:0] unused;
    xfer(1'b1, a, flagMask | (flagMask >> 1), unused);
  endtask
endmodule // host_model

// >>> dv/fault_interrupt_status_tb.sv
// Testbench of the fault status block: table of faults, then hand tests.
// Assumes the design header and package are compiled before this file.
`include "fault_irq_map.svh"
module fault_interrupt_status_tb
  import fault_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_PEN = 12'(`IDX_PWR_ENABLE << 2);  // Power enable.
  localparam logic [11:0] A_LEN = 12'(`IDX_LED_ENABLE << 2);  // LED enable.
  localparam logic [11:0] A_PST = 12'(`IDX_PWR_STATUS << 2);  // Power status.
  localparam logic [11:0] A_LST = 12'(`IDX_LED_FLAGS << 2);  // String_fault_summary_flag.
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, faultIrq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [6:0]  pwrFaultSet = '0;
  logic [5:0]  chanFaultSet = '0;
  logic        openFaultSet = 1'b0;
  logic        shortFaultSet = 1'b0;
  int          nMismatch = 0;
  int          comparisons = 0;
  // One row: set pulses, status word, expected flags, clear mask, expected pin.
  typedef struct packed {
    logic [6:0] pwr; logic [7:0] led; logic [11:0] addr;
    logic [15:0] flags; logic [15:0] clr; logic irq;
  } row_s;
  row_s rows [11] = '{
    '{7'h40, 8'h00, A_PST, 16'h8000, 16'h8000, 1'b1},
    '{7'h20, 8'h00, A_PST, 16'h2000, 16'h2000, 1'b0},
    '{7'h10, 8'h00, A_PST, 16'h0800, 16'h0800, 1'b0},
    '{7'h08, 8'h00, A_PST, 16'h0080, 16'h0080, 1'b0},
    '{7'h04, 8'h00, A_PST, 16'h0020, 16'h0020, 1'b1},
    '{7'h02, 8'h00, A_PST, 16'h0008, 16'h0008, 1'b1},
    '{7'h01, 8'h00, A_PST, 16'h0002, 16'h0002, 1'b1},
    '{7'h00, 8'hFC, A_LST, 16'hFC80, 16'h0080, 1'b1},
    '{7'h00, 8'h04, A_LST, 16'h0480, 16'h0080, 1'b1},
    '{7'h00, 8'h02, A_LST, 16'h0280, 16'h0080, 1'b1},
    '{7'h00, 8'h01, A_LST, 16'h0180, 16'h0080, 1'b1}};

  fault_interrupt_status fault_interrupt_status_inst (
    .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwrFaultSet(pwrFaultSet), .chanFaultSet(chanFaultSet),
    .openFaultSet(openFaultSet), .shortFaultSet(shortFaultSet), .faultIrq(faultIrq));
  host_model host_model_inst (
    .sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Free-running 50 MHz clock.
  always #10 sys_clk = ~sys_clk;

  // Word compare, counted.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Single-bit compare, counted.
  task automatic chkBit(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask
  // One-cycle set pulses launched just after a rising edge.
  task automatic pulse(input logic [6:0] p, input logic [7:0] l);
    @(posedge sys_clk);
    pwrFaultSet <= p;
    {chanFaultSet, openFaultSet, shortFaultSet} <= l;
    @(posedge sys_clk);
    pwrFaultSet <= '0;
    {chanFaultSet, openFaultSet, shortFaultSet} <= '0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    host_model_inst.xfer(1'b0, a, 16'h0000, r);
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] unused;
    host_model_inst.xfer(1'b1, a, d, unused);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog cuts a hung run short.
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    nMismatch++;
    $display("wrong value watchdog expected done seen hang");
    final_report();
  end

  // Main sequence.
  initial
  begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    rd(A_PEN, v); chk("power enable", 32'hA02A, v);
    rd(A_LEN, v); chk("led enable", 32'h0080, v);
    rd(A_PST, v); chk("power status", 32'h0, v);
    rd(A_LST, v); chk("string_fault_summary_flag", 32'h0, v);
    chkBit("faultIrq", 1'b0, faultIrq);
    $display("test reset values done");
    // Each row latches a fault, reads it, clears it in a pair, reads zero.
    foreach (rows[i])
    begin
      pulse(rows[i].pwr, rows[i].led);
      rd(rows[i].addr, v); chk("flags", {16'h0, rows[i].flags}, v);
      chkBit("faultIrq", rows[i].irq, faultIrq);
      host_model_inst.clear_pair(rows[i].addr, rows[i].clr);
      rd(rows[i].addr, v); chk("flags cleared", 32'h0, v);
      chkBit("faultIrq cleared", 1'b0, faultIrq);
    end
    $display("test fault table done");
    // Lone status or lone clear writes leave latched faults alone.
    pulse(7'h01, 8'h02);
    wr(A_PST, 16'h0002); wr(A_PST, 16'h0001); wr(A_LST, 16'h0080); wr(A_LST, 16'h0040);
    rd(A_PST, v); chk("power lone write", 32'h0002, v);
    rd(A_LST, v); chk("led lone write", 32'h0280, v);
    chkBit("faultIrq lone write", 1'b1, faultIrq);
    host_model_inst.clear_pair(A_PST, 16'h0002);
    host_model_inst.clear_pair(A_LST, 16'h0080);
    $display("test lone writes done");
    // Enable codes: 3h enables, 1h disables, global gates the pin.
    wr(A_PEN, 16'h0C00); rd(A_PEN, v); chk("temp enabled", 32'hA82A, v);
    pulse(7'h10, 8'h00);
    @(posedge sys_clk);
    chkBit("faultIrq temp", 1'b1, faultIrq);
    wr(A_PEN, 16'h4000); rd(A_PEN, v); chk("global off", 32'h282A, v);
    chkBit("faultIrq global off", 1'b0, faultIrq);
    host_model_inst.clear_pair(A_PST, 16'h0800);
    wr(A_PEN, 16'hC000);
    wr(A_LEN, 16'h0040); rd(A_LEN, v); chk("led enable off", 32'h0, v);
    pulse(7'h00, 8'h01);
    rd(A_LST, v); chk("short latched", 32'h0180, v);
    chkBit("faultIrq led off", 1'b0, faultIrq);
    $display("test enables done");
    // Unmapped read answers zero with an error.
    rd(12'h144, v); chk("unmapped read", 32'h0, v);
    chkBit("pslverr", 1'b1, host_model_inst.lastErr);
    chkBit("pready", 1'b1, pready);
    $display("test unmapped read done");
    // A second reset in mid-run clears flags and restores enables.
    pulse(7'h01, 8'h00);
    @(posedge sys_clk);
    chkBit("faultIrq before reset", 1'b1, faultIrq);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    rd(A_PST, v); chk("power after reset", 32'h0, v);
    chkBit("faultIrq after reset", 1'b0, faultIrq);
    rd(A_LST, v); chk("led after reset", 32'h0, v);
    rd(A_PEN, v); chk("enable after reset", 32'hA02A, v);
    chkBit("host hang", 1'b0, host_model_inst.hung);
    $display("test mid-run reset done");
    final_report();
  end
endmodule // fault_interrupt_status_tb
